// file: design/frs_pkg.sv
// frs_pkg: shared constants for the round/estimate/select unit.
// assumes instruction words are numbered msb-first (bit 0 is the msb).
package frs_pkg;
  // instruction fields (bit 0 = word bit 31)
  localparam logic [5:0] OP_PRIMARY   = 6'h3F;
  localparam logic [9:0] XO_ROUND     = 10'h00C;
  localparam logic [4:0] XO_RSQRT     = 5'h1A;
  localparam logic [4:0] XO_SELECT    = 5'h17;
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_INSN     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_CR1      = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_FPR_IDX  = 8'h14;
  localparam logic [7:0] OFF_FPR_LO   = 8'h18;
  localparam logic [7:0] OFF_FPR_HI   = 8'h1C;
  localparam logic [7:0] OFF_DEP_CNT  = 8'h20;
  // status/control bit positions (lsb numbering)
  localparam int B_FX    = 31;
  localparam int B_FEX   = 30;
  localparam int B_VX    = 29;
  localparam int B_OX    = 28;
  localparam int B_UX    = 27;
  localparam int B_ZX    = 26;
  localparam int B_XX    = 25;
  localparam int B_VXSN  = 24;
  localparam int B_VXSQ  = 9;
  localparam int B_FR    = 18;
  localparam int B_FI    = 17;
  localparam int B_RESULT_CLASS_FLAGS  = 12;
  localparam int B_VE    = 7;
  localparam int B_OE    = 6;
  localparam int B_UE    = 5;
  localparam int B_ZE    = 4;
  localparam int B_XE    = 3;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  // result classes: {c, <, >, =, ?}
  localparam logic [4:0] CL_QNAN  = 5'h11;
  localparam logic [4:0] CL_NINF  = 5'h09;
  localparam logic [4:0] CL_NNORM = 5'h08;
  localparam logic [4:0] CL_NZERO = 5'h12;
  localparam logic [4:0] CL_PZERO = 5'h02;
  localparam logic [4:0] CL_PNORM = 5'h04;
  localparam logic [4:0] CL_PINF  = 5'h05;
  localparam logic [4:0] CL_NDEN  = 5'h18;
  localparam logic [4:0] CL_PDEN  = 5'h14;
  localparam logic [63:0] QNAN_DEF = 64'h7FF8_0000_0000_0000;
  localparam int DEP_WINDOW = 2;
  // interrupt status bits
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_EXC   = 1;
  localparam int IRQ_ILL   = 2;
  typedef enum logic [1:0] {FRS_OP_NONE, FRS_OP_ROUND, FRS_OP_RSQRT, FRS_OP_SEL} frs_op_t;
endpackage

// file: design/frs_decode.sv
// frs_decode: splits an instruction word into operation and register fields.
// assumes the word is already stable on the same clock.
`timescale 1ns/1ps
module frs_decode (
  input  wire logic [31:0]   insn,
  output frs_pkg::frs_op_t   op,
  output logic [4:0]         target_fp_reg,
  output logic [4:0]         source_a_fp_reg,
  output logic [4:0]         source_b_fp_reg,
  output logic [4:0]         source_c_fp_reg,
  output logic               record_bit
);
  // bit n of the word (msb-first) is insn[31-n]
  wire [5:0] primary  = insn[31:26];
  wire [9:0] ext_long = insn[10:1];
  wire [4:0] ext_sh   = insn[5:1];
  wire       is_prim  = primary == frs_pkg::OP_PRIMARY;
  wire       is_round = is_prim && ext_long == frs_pkg::XO_ROUND;
  wire       is_rsq   = is_prim && ext_sh == frs_pkg::XO_RSQRT;
  wire       is_sel   = is_prim && ext_sh == frs_pkg::XO_SELECT;
  assign target_fp_reg   = insn[25:21];
  assign source_a_fp_reg = insn[20:16];
  assign source_b_fp_reg = insn[15:11];
  assign source_c_fp_reg = insn[10:6];
  assign record_bit      = insn[0];
  assign op = is_round ? frs_pkg::FRS_OP_ROUND :
              is_rsq   ? frs_pkg::FRS_OP_RSQRT :
              is_sel   ? frs_pkg::FRS_OP_SEL : frs_pkg::FRS_OP_NONE;
endmodule

// file: design/frs_round.sv
// frs_round: rounds a double to single precision, result kept in double format.
// assumes the rounding mode is steady while the operand is presented.
`timescale 1ns/1ps
module frs_round (
  input  wire logic [63:0] src,
  input  wire logic [1:0]  rounding_mode_field,
  output logic [63:0]      res,
  output logic             snan,
  output logic             ovf,
  output logic             unf,
  output logic             inexact,
  output logic             rounded_up,
  output logic             edge_128
);
  wire        sgn   = src[63];
  wire [10:0] ex    = src[62:52];
  wire [51:0] fr    = src[51:0];
  wire        is_nan = ex == 11'h7FF && fr != 52'h0;
  wire        is_inf = ex == 11'h7FF && fr == 52'h0;
  wire        is_zer = ex == 11'h000 && fr == 52'h0;
  // single normal range: double exponent 897..1150
  wire        tiny   = ex < 11'h381;
  wire [28:0] low    = fr[28:0];
  wire        guard  = fr[28];
  wire        sticky = fr[27:0] != 28'h0;
  wire        lsb    = fr[29];
  wire        inx    = low != 29'h0;
  logic       up;
  always_comb
  begin
    case (rounding_mode_field)
      2'h0:    up = guard && (sticky || lsb);
      2'h1:    up = 1'b0;
      2'h2:    up = !sgn && inx;
      default: up = sgn && inx;
    endcase
  end
  wire [23:0] mant_up = {1'b0, fr[51:29]} + 24'h1;
  wire [10:0] ex_up   = mant_up[23] ? ex + 11'h1 : ex;
  wire [22:0] fr_r    = up ? mant_up[22:0] : fr[51:29];
  wire [10:0] ex_r    = up ? ex_up : ex;
  wire        big     = ex_r > 11'h47E;
  always_comb
  begin
    snan       = is_nan && !fr[51];
    ovf        = 1'b0;
    unf        = 1'b0;
    inexact    = 1'b0;
    rounded_up = 1'b0;
    edge_128   = 1'b0;
    if (is_nan)
      res = {sgn, 11'h7FF, 1'b1, fr[50:29], 29'h0};
    else if (is_inf || is_zer)
      res = src;
    else if (tiny)
    begin
      // flush to signed zero; no denormal support
      res     = {sgn, 63'h0};
      unf     = 1'b1;
      inexact = 1'b1;
    end
    else
    begin
      inexact    = inx;
      rounded_up = up;
      // a value below 2**128 rounding up to exactly 2**128
      edge_128 = ex == 11'h47E && up && ex_r == 11'h47F;
      ovf      = big;
      // held in double format so later double ops read it unconverted
      res = big ? {sgn, 11'h7FF, 52'h0} : {sgn, ex_r, fr_r, 29'h0};
    end
  end
endmodule

// file: design/frs_unit.sv
// frs_unit: round-to-single, reciprocal square root estimate and select.
// assumes an apb master on mclk; instructions arrive by a write to the insn register.
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
module frs_unit #(
  parameter int NREG = 32
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  logic [63:0] fpr_r [NREG];
  logic [31:0] fp_status_control_r;
  logic [3:0]  condition_field_one_r;
  logic [2:0]  irq_stat_r;
  logic [2:0]  irq_mask_r;
  logic [4:0]  fpr_idx_r;
  logic [4:0]  last_arith_tgt_r;
  logic [1:0]  dep_cnt_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        irq_r;

  wire acc = psel && penable && !pready_r;
  wire wr  = acc && pwrite;
  wire rd  = acc && !pwrite;
  wire known = paddr inside {frs_pkg::OFF_INSN, frs_pkg::OFF_STATUS, frs_pkg::OFF_CR1,
                             frs_pkg::OFF_IRQ_STAT, frs_pkg::OFF_IRQ_MASK,
                             frs_pkg::OFF_FPR_IDX, frs_pkg::OFF_FPR_LO,
                             frs_pkg::OFF_FPR_HI, frs_pkg::OFF_DEP_CNT};
  wire issue = wr && paddr == frs_pkg::OFF_INSN;

  frs_pkg::frs_op_t op;
  logic [4:0] tgt, ra, rb, rc;
  logic       record_bit;
  frs_decode u_dec (
    .insn            (pwdata),
    .op              (op),
    .target_fp_reg   (tgt),
    .source_a_fp_reg (ra),
    .source_b_fp_reg (rb),
    .source_c_fp_reg (rc),
    .record_bit      (record_bit)
  );

  wire [31:0] st  = fp_status_control_r;
  wire [63:0] vb  = fpr_r[rb];
  wire [63:0] va  = fpr_r[ra];
  wire [63:0] vc  = fpr_r[rc];
  wire        invalid_enable     = st[frs_pkg::B_VE];
  wire        zero_divide_enable = st[frs_pkg::B_ZE];

  // round path
  logic [63:0] rnd_res;
  logic rnd_snan, rnd_ovf, rnd_unf, rnd_inx, rnd_up, rnd_edge;
  frs_round u_rnd (
    .src                 (vb),
    .rounding_mode_field (st[1:0]),
    .res                 (rnd_res),
    .snan                (rnd_snan),
    .ovf                 (rnd_ovf),
    .unf                 (rnd_unf),
    .inexact             (rnd_inx),
    .rounded_up          (rnd_up),
    .edge_128            (rnd_edge)
  );
  // defect: dependent on a recent arithmetic result
  wire defect = rnd_edge && rb == last_arith_tgt_r && dep_cnt_r < 2'(frs_pkg::DEP_WINDOW);
  wire [63:0] rnd_out = defect ? {vb[63], 11'h47F, 52'h0} : rnd_res;
  wire rnd_ovf_eff = rnd_ovf && !defect;

  // class of a double value
  function automatic logic [4:0] frs_class(input logic [63:0] v);
    logic [10:0] e;
    logic        z;
    e = v[62:52];
    z = v[51:0] == 52'h0;
    if (e == 11'h7FF && !z)       frs_class = frs_pkg::CL_QNAN;
    else if (e == 11'h7FF)        frs_class = v[63] ? frs_pkg::CL_NINF : frs_pkg::CL_PINF;
    else if (e == 11'h000 && z)   frs_class = v[63] ? frs_pkg::CL_NZERO : frs_pkg::CL_PZERO;
    else if (e == 11'h000)        frs_class = v[63] ? frs_pkg::CL_NDEN : frs_pkg::CL_PDEN;
    else                          frs_class = v[63] ? frs_pkg::CL_NNORM : frs_pkg::CL_PNORM;
  endfunction

  // estimate path: halve and negate exponent, table mantissa guess
  wire [10:0] eb      = vb[62:52];
  wire        b_nan   = eb == 11'h7FF && vb[51:0] != 52'h0;
  wire        b_snan  = b_nan && !vb[51];
  wire        b_inf   = eb == 11'h7FF && vb[51:0] == 52'h0;
  wire        b_zero  = eb == 11'h000 && vb[51:0] == 52'h0;
  wire        b_neg   = vb[63] && !b_nan && !b_zero;
  wire [11:0] e_unb   = {1'b0, eb} - 12'h3FF;
  wire [11:0] e_half  = {e_unb[11], e_unb[11:1]};
  // fraction byte per segment: index {odd exponent, top 4 fraction bits}, segment midpoints
  localparam logic [255:0] RSQ_TAB =
    256'h02060B0F_14191F25_2B313840_48515A65_6D737980_878E969E_A6B0BAC4_D0DCEAF8;
  // result exponent is -floor(e/2)-1 for both parities; fraction from the table
  wire [11:0] e_est   = 12'h3FF - e_half - 12'h001;
  wire [4:0]  tab_i   = {e_unb[0], vb[51:48]};
  wire [51:0] m_est   = {RSQ_TAB[{tab_i, 3'h0} +: 8], 44'h0};
  wire [63:0] est_num = {1'b0, e_est[10:0], m_est};
  logic [63:0] est_res;
  logic        est_vxsq, est_zx, est_vxsn;
  always_comb
  begin
    est_vxsq = 1'b0;
    est_zx   = 1'b0;
    est_vxsn = 1'b0;
    if (b_snan)
    begin
      est_res  = vb | 64'h0008_0000_0000_0000;
      est_vxsn = 1'b1;
    end
    else if (b_nan)
      est_res = vb;
    else if (b_zero)
    begin
      est_res = {vb[63], 11'h7FF, 52'h0};
      est_zx  = 1'b1;
    end
    else if (b_neg)
    begin
      est_res  = frs_pkg::QNAN_DEF;
      est_vxsq = 1'b1;
    end
    else if (b_inf)
      est_res = 64'h0;
    else
      est_res = est_num;
  end
  wire est_inv   = est_vxsn || est_vxsq;
  wire est_block = (est_inv && invalid_enable) || (est_zx && zero_divide_enable);

  // select: nan or negative nonzero takes b
  wire a_nan = va[62:52] == 11'h7FF && va[51:0] != 52'h0;
  wire a_ge  = !a_nan && (!va[63] || va[62:0] == 63'h0);
  wire [63:0] sel_res = a_ge ? vc : vb;

  // status next value
  logic [31:0] st_new;
  logic        fl_set;
  logic [63:0] wb_val;
  logic        wb_en;
  always_comb
  begin
    st_new = st;
    wb_en  = 1'b0;
    wb_val = 64'h0;
    fl_set = 1'b0;
    case (op)
      frs_pkg::FRS_OP_ROUND:
      begin
        st_new[frs_pkg::B_FR] = rnd_up;
        st_new[frs_pkg::B_FI] = rnd_inx;
        st_new[frs_pkg::B_OX]   = st[frs_pkg::B_OX] | rnd_ovf_eff;
        st_new[frs_pkg::B_UX]   = st[frs_pkg::B_UX] | rnd_unf;
        st_new[frs_pkg::B_XX]   = st[frs_pkg::B_XX] | rnd_inx;
        st_new[frs_pkg::B_VXSN] = st[frs_pkg::B_VXSN] | rnd_snan;
        fl_set = rnd_ovf_eff | rnd_unf | rnd_inx | rnd_snan;
        if (!(rnd_snan && invalid_enable))
        begin
          // defect case classes the clamped magnitude as a finite normal
          st_new[frs_pkg::B_RESULT_CLASS_FLAGS +: 5] = defect
            ? (vb[63] ? frs_pkg::CL_NNORM : frs_pkg::CL_PNORM)
            : frs_class(rnd_out);
          wb_en  = 1'b1;
          wb_val = rnd_out;
        end
      end
      frs_pkg::FRS_OP_RSQRT:
      begin
        st_new[frs_pkg::B_FR]   = 1'b0;
        st_new[frs_pkg::B_FI]   = !est_inv && !est_zx && !b_inf && !b_nan;
        st_new[frs_pkg::B_ZX]   = st[frs_pkg::B_ZX] | est_zx;
        st_new[frs_pkg::B_VXSN] = st[frs_pkg::B_VXSN] | est_vxsn;
        st_new[frs_pkg::B_VXSQ] = st[frs_pkg::B_VXSQ] | est_vxsq;
        // fraction-inexact is not an exception and leaves the summary alone
        fl_set = est_zx | est_inv;
        if (!est_block)
        begin
          st_new[frs_pkg::B_RESULT_CLASS_FLAGS +: 5] = frs_class(est_res);
          wb_en  = 1'b1;
          wb_val = est_res;
        end
      end
      frs_pkg::FRS_OP_SEL:
      begin
        wb_en  = 1'b1;
        wb_val = sel_res;
      end
      default:
      begin
        wb_en = 1'b0;
      end
    endcase
    st_new[frs_pkg::B_FX] = st[frs_pkg::B_FX] | fl_set;
    st_new[frs_pkg::B_VX] = st_new[frs_pkg::B_VXSN] | st_new[frs_pkg::B_VXSQ];
    st_new[frs_pkg::B_FEX] = |(st_new[28:25] & {st[frs_pkg::B_OE], st[frs_pkg::B_UE],
                             st[frs_pkg::B_ZE], st[frs_pkg::B_XE]})
                             | (st_new[frs_pkg::B_VX] & invalid_enable);
  end
  wire is_op   = op != frs_pkg::FRS_OP_NONE;
  wire st_upd  = issue && (op == frs_pkg::FRS_OP_ROUND || op == frs_pkg::FRS_OP_RSQRT);
  wire [3:0] cr_val = {st_new[frs_pkg::B_FX], st_new[frs_pkg::B_FEX],
                       st_new[frs_pkg::B_VX], st_new[frs_pkg::B_OX]};
  wire exc_evt = st_upd && st_new[frs_pkg::B_FX] && !st[frs_pkg::B_FX];

  logic [31:0] rd_mux;
  always_comb
  begin
    case (paddr)
      frs_pkg::OFF_STATUS:   rd_mux = fp_status_control_r;
      frs_pkg::OFF_CR1:      rd_mux = {28'h0, condition_field_one_r};
      frs_pkg::OFF_IRQ_STAT: rd_mux = {29'h0, irq_stat_r};
      frs_pkg::OFF_IRQ_MASK: rd_mux = {29'h0, irq_mask_r};
      frs_pkg::OFF_FPR_IDX:  rd_mux = {27'h0, fpr_idx_r};
      frs_pkg::OFF_FPR_LO:   rd_mux = fpr_r[fpr_idx_r][31:0];
      frs_pkg::OFF_FPR_HI:   rd_mux = fpr_r[fpr_idx_r][63:32];
      frs_pkg::OFF_DEP_CNT:  rd_mux = {27'h0, last_arith_tgt_r};
      default:               rd_mux = 32'h0;
    endcase
  end
  wire [2:0] irq_evt = {issue && !is_op, exc_evt, issue && is_op};
  wire clr_stat = rd && paddr == frs_pkg::OFF_IRQ_STAT;
  wire [2:0] irq_stat_nxt = (clr_stat ? 3'h0 : irq_stat_r) | irq_evt;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      fp_status_control_r   <= frs_pkg::STATUS_RST;
      condition_field_one_r <= 4'h0;
      irq_stat_r <= 3'h0;
      irq_mask_r <= 3'h0;
      fpr_idx_r  <= 5'h0;
      last_arith_tgt_r <= 5'h0;
      dep_cnt_r  <= 2'h3;
      prdata_r   <= 32'h0;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      irq_r      <= 1'b0;
    end
    else
    begin
      pready_r  <= acc;
      pslverr_r <= acc && !known;
      prdata_r  <= rd ? rd_mux : 32'h0;
      irq_stat_r <= irq_stat_nxt;
      irq_r <= |(irq_stat_nxt & irq_mask_r);
      if (st_upd)
        fp_status_control_r <= st_new;
      else if (wr && paddr == frs_pkg::OFF_STATUS)
        fp_status_control_r <= pwdata;
      if (issue && is_op && record_bit)
        condition_field_one_r <= cr_val;
      if (wr && paddr == frs_pkg::OFF_IRQ_MASK)
        irq_mask_r <= pwdata[2:0];
      if (wr && paddr == frs_pkg::OFF_FPR_IDX)
        fpr_idx_r <= pwdata[4:0];
      // an fpr write stands in for an arithmetic result; ops to another target count as separators
      if (wr && (paddr == frs_pkg::OFF_FPR_LO || paddr == frs_pkg::OFF_FPR_HI))
      begin
        last_arith_tgt_r <= fpr_idx_r;
        dep_cnt_r <= 2'h0;
      end
      else if (issue && is_op && tgt != last_arith_tgt_r && dep_cnt_r != 2'h3)
        dep_cnt_r <= dep_cnt_r + 2'h1;
    end
  end

  for (genvar i = 0; i < NREG; i++)
  begin : g_fpr
    always_ff @(posedge mclk or posedge rst)
    begin
      if (rst)
        fpr_r[i] <= 64'h0;
      else if (issue && wb_en && tgt == 5'(i))
        fpr_r[i] <= wb_val;
      else if (wr && paddr == frs_pkg::OFF_FPR_LO && fpr_idx_r == 5'(i))
        fpr_r[i][31:0] <= pwdata;
      else if (wr && paddr == frs_pkg::OFF_FPR_HI && fpr_idx_r == 5'(i))
        fpr_r[i][63:32] <= pwdata;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign irq     = irq_r;

  chk_sel_nochg: assert property (@(posedge mclk) disable iff (rst)
    issue && op == frs_pkg::FRS_OP_SEL |=> $stable(fp_status_control_r))
    else $error("select changed status");
  chk_cr_hold: assert property (@(posedge mclk) disable iff (rst)
    issue && !record_bit |=> $stable(condition_field_one_r))
    else $error("cr1 changed without record bit");
  chk_sel_pick: assert property (@(posedge mclk) disable iff (rst)
    issue && op == frs_pkg::FRS_OP_SEL && a_nan |-> wb_val == vb)
    else $error("nan compare did not pick b");
  chk_est_block: assert property (@(posedge mclk) disable iff (rst)
    issue && op == frs_pkg::FRS_OP_RSQRT && est_block |=> $stable(fpr_r[$past(tgt)]))
    else $error("blocked estimate wrote target");
  chk_est_zero: assert property (@(posedge mclk) disable iff (rst)
    issue && op == frs_pkg::FRS_OP_RSQRT && b_zero && !zero_divide_enable
    |=> fp_status_control_r[frs_pkg::B_ZX])
    else $error("zero operand did not set zero divide");
  chk_defect_ox: assert property (@(posedge mclk) disable iff (rst)
    issue && op == frs_pkg::FRS_OP_ROUND && defect && !st[frs_pkg::B_OX]
    |=> !fp_status_control_r[frs_pkg::B_OX])
    else $error("defect case raised overflow");
  chk_apb_ready: assert property (@(posedge mclk) disable iff (rst)
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb ready not one cycle");
  chk_irq_level: assert property (@(posedge mclk) disable iff (rst)
    irq |-> $past(|(irq_stat_nxt & irq_mask_r)))
    else $error("irq without masked status");
endmodule

// file: verification/frs_apb_master.sv
// frs_apb_master: sequencer-side apb master that issues one transfer per call.
// assumes a registered slave that raises pready once per access.
`timescale 1ns/1ps
module frs_apb_master (
  input  wire logic        mclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // request held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data lines show a changing pattern, never the last value
    pwdata <= ~d;
  endtask
endmodule

// file: verification/tb_top.sv
// tb_top: self-checking bench for the round/estimate/select unit.
// assumes frs_pkg constants and the apb register map of frs_unit.
`timescale 1ns/1ps
module tb_top;
  logic        mclk = 1'b0;
  logic        rst  = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, e, k;
  logic [63:0] v, vb, vc;
  logic        er;
  logic [31:0] exp_q[$], msk_q[$];
  logic        err_q[$];
  int          bad_count = 0;
  int          comparisons = 0;
  real         dv;
  always #12.5 mclk = ~mclk;

  frs_unit #(.NREG(32)) uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  frs_apb_master m (.mclk(mclk), .pready(pready), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  task automatic fail(input string s);
    bad_count++;
    $display("[ERR] %0t %s", $time, s);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // monitor: each completed read takes the oldest note
  always @(posedge mclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      comparisons++;
      if (exp_q.size() == 0)
        fail("read with no note");
      else
      begin
        e = exp_q.pop_front();
        k = msk_q.pop_front();
        er = err_q.pop_front();
        if ((prdata & k) !== e || pslverr !== er)
          fail($sformatf("addr %h got %h/%b want %h/%b", paddr, prdata, pslverr, e, er));
      end
    end

  function automatic logic [31:0] i_rnd(input logic [4:0] t, b, input logic rc);
    return {6'h3F, t, 5'h00, b, frs_pkg::XO_ROUND, rc};
  endfunction
  function automatic logic [31:0] i_rsq(input logic [4:0] t, b, input logic rc);
    return {6'h3F, t, 5'h00, b, 5'h00, frs_pkg::XO_RSQRT, rc};
  endfunction
  function automatic logic [31:0] i_sel(input logic [4:0] t, a, b, c, input logic rc);
    return {6'h3F, t, a, b, c, frs_pkg::XO_SELECT, rc};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] j;
    m.xfer(1'b1, a, d, j);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, mk, input logic r);
    exp_q.push_back(x & mk);
    msk_q.push_back(mk);
    err_q.push_back(r);
    m.xfer(1'b0, a, 32'h0000_0000, q);
  endtask
  task automatic fset(input logic [4:0] i, input logic [63:0] d);
    wr(frs_pkg::OFF_FPR_IDX, {27'h0, i});
    wr(frs_pkg::OFF_FPR_LO, d[31:0]);
    wr(frs_pkg::OFF_FPR_HI, d[63:32]);
  endtask
  task automatic fchk(input logic [4:0] i, input logic [63:0] d, input logic [31:0] mh, ml);
    wr(frs_pkg::OFF_FPR_IDX, {27'h0, i});
    rd(frs_pkg::OFF_FPR_LO, d[31:0], ml, 1'b0);
    v[31:0] = q;
    rd(frs_pkg::OFF_FPR_HI, d[63:32], mh, 1'b0);
    v[63:32] = q;
  endtask
  task automatic st(input logic [31:0] d);
    wr(frs_pkg::OFF_STATUS, d);
  endtask
  task automatic irq_is(input logic x);
    for (int i = 0; i < 4 && irq !== x; i++) @(posedge mclk);
    comparisons++;
    if (irq !== x)
      fail("irq level wrong");
  endtask

  logic [63:0] sa [6] = '{64'h3FF0_0000_0000_0000, 64'h8000_0000_0000_0000, 64'h0,
                         64'hBFF0_0000_0000_0000, 64'h7FF8_0000_0000_0000, 64'h8000_0000_0000_0001};
  logic [63:0] ri [7] = '{64'hFFF0_0000_0000_0000, 64'hBFF0_0000_0000_0000,
                         64'h8000_0000_0000_0000, 64'h0, 64'h7FF0_0000_0000_0000,
                         64'h7FF0_0000_0000_0001, 64'h7FF8_0000_0000_0000};
  logic [31:0] rh [7] = '{32'h7FF8_0000, 32'h7FF8_0000, 32'hFFF0_0000, 32'h7FF0_0000, 0,
                         32'h7FF8_0000, 32'h7FF8_0000};
  logic [31:0] rm [7] = '{32'h7FF8_0000, 32'h7FF8_0000, '1, '1, '1, 32'h7FF8_0000, 32'h7FF8_0000};
  logic [31:0] rs [7] = '{32'h0001_1200, 32'h0001_1200, 32'h0400_9000, 32'h0400_5000,
                         32'h0000_2000, 32'h0101_1000, 32'h0001_1000};

  initial
  begin
    #2_000_000;
    fail("watchdog expired");
    conclude();
  end
  initial
  begin
    void'($urandom(32'h3123));
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    st(32'h9000_0000);
    for (int i = 0; i < 6; i++)
    begin
      vb = {$urandom, $urandom};
      vc = {$urandom, $urandom};
      fset(1, sa[i]);
      fset(2, vb);
      fset(3, vc);
      wr(frs_pkg::OFF_INSN, i_sel(4, 1, 2, 3, i == 0));
      fchk(4, (i < 3) ? vc : vb, '1, '1);
      rd(frs_pkg::OFF_STATUS, 32'h9000_0000, '1, 1'b0);
    end
    rd(frs_pkg::OFF_CR1, 32'h9, 32'hF, 1'b0);
    st(0);
    wr(frs_pkg::OFF_INSN, i_sel(4, 1, 2, 3, 1'b0));
    rd(frs_pkg::OFF_CR1, 32'h9, 32'hF, 1'b0);
    $display("test select done");
    fset(4, 64'hC053_4000_0000_0000);
    wr(frs_pkg::OFF_INSN, i_rnd(6, 4, 1'b0));
    fchk(6, 64'hC053_4000_0000_0000, '1, '1);
    rd(frs_pkg::OFF_STATUS, 32'h0000_8000, '1, 1'b0);
    fset(4, '1);
    wr(frs_pkg::OFF_INSN, i_rnd(6, 4, 1'b1));
    fchk(6, 64'hFFFF_FFFF_E000_0000, '1, '1);
    rd(frs_pkg::OFF_STATUS, 32'h0001_1000, '1, 1'b0);
    rd(frs_pkg::OFF_CR1, 32'h0, 32'hF, 1'b0);
    st(0);
    fset(3, 64'h47EF_FFFF_FFFF_FFFF);
    wr(frs_pkg::OFF_INSN, i_rnd(7, 3, 1'b0));
    fchk(7, 64'h47F0_0000_0000_0000, '1, '1);
    rd(frs_pkg::OFF_STATUS, 32'h0000_4000, 32'h1001_F000, 1'b0);
    st(0);
    fset(3, 64'h47EF_FFFF_FFFF_FFFF);
    wr(frs_pkg::OFF_INSN, i_sel(10, 0, 0, 0, 1'b0));
    wr(frs_pkg::OFF_INSN, i_sel(11, 0, 0, 0, 1'b0));
    wr(frs_pkg::OFF_INSN, i_rnd(7, 3, 1'b0));
    fchk(7, 64'h7FF0_0000_0000_0000, '1, '1);
    rd(frs_pkg::OFF_STATUS, 32'h1000_5000, 32'h1001_F000, 1'b0);
    $display("test round done");
    for (int i = 0; i < 7; i++)
    begin
      st(0);
      fset(5, ri[i]);
      wr(frs_pkg::OFF_INSN, i_rsq(6, 5, 1'b0));
      fchk(6, {rh[i], 32'h0}, rm[i], 32'h0);
      rd(frs_pkg::OFF_STATUS, rs[i], 32'h0501_F200, 1'b0);
    end
    for (int i = 0; i < 2; i++)
    begin
      st(i ? 32'h10 : 32'h80);
      fset(6, 64'h1234_5678_9ABC_DEF0);
      fset(5, i ? 64'h0 : 64'hBFF0_0000_0000_0000);
      wr(frs_pkg::OFF_INSN, i_rsq(6, 5, 1'b0));
      fchk(6, 64'h1234_5678_9ABC_DEF0, '1, '1);
    end
    st(0);
    for (int i = 0; i < 6; i++)
    begin
      vb = {1'b0, 11'h3F0 + 11'($urandom % 32), 20'($urandom), 32'($urandom)};
      fset(5, vb);
      wr(frs_pkg::OFF_INSN, i_rsq(6, 5, 1'b1));
      fchk(6, 64'h0, 32'h0, 32'h0);
      dv = $bitstoreal(v) * $sqrt($bitstoreal(vb)) - 1.0;
      comparisons++;
      if (dv > 1.0 / 32 || dv < -1.0 / 32)
        fail("estimate out of range");
      rd(frs_pkg::OFF_CR1, 32'h0, 32'hF, 1'b0);
    end
    $display("test estimate done");
    rd(8'h40, 32'h0, '1, 1'b1);
    wr(frs_pkg::OFF_IRQ_MASK, 32'h4);
    rd(frs_pkg::OFF_IRQ_STAT, 32'h0, 32'h0, 1'b0);
    irq_is(1'b0);
    wr(frs_pkg::OFF_INSN, 32'h0000_0000);
    irq_is(1'b1);
    rd(frs_pkg::OFF_IRQ_STAT, 32'h4, '1, 1'b0);
    irq_is(1'b0);
    wr(frs_pkg::OFF_IRQ_MASK, 32'h0);
    wr(frs_pkg::OFF_INSN, 32'h0000_0000);
    irq_is(1'b0);
    $display("test bus and irq done");
    conclude();
  end
endmodule
